//--- icph_top.sv
`timescale 1ns/1ps

// Operation
// - Upstream wake inputs ask for the clock while a port has traffic.
// - A downstream wake output is high while its port has pending work.
// - The register-port wake-up input counts as a need for the clock.
// - The clock-needed output is high while the block needs its clock.
// - Power state codes are off, static retention, dynamic retention and on.
// - A power state request is answered by transition accept or deny.
// - The activity hint flags which power transitions are legal now.
// - All logic runs on one clock and one reset.
module icph_top (
   input  wire logic                              clk,
   input  wire logic                              rst_b,
   input  wire logic [icph_pkg::NUM_UP-1:0]       upstream_port_wake_in,
   input  wire logic [icph_pkg::NUM_DOWN-1:0]     down_pending,
   input  wire logic                              regport_wake_in,
   input  wire logic                              busy,
   input  wire logic                              clk_quiesce_req_n,
   input  wire logic                              pwr_req,
   input  wire logic [2:0]                        pwr_state,
   output logic      [icph_pkg::NUM_DOWN-1:0]     downstream_port_wake_out,
   output logic                                   clk_needed,
   output logic                                   clk_quiesce_accept_n,
   output logic                                   clk_quiesce_deny,
   output logic                                   pwr_accept,
   output logic                                   pwr_deny,
   output logic      [4:0]                        pwr_active,
   output logic      [2:0]                        pwr_cur_state
);

   // ------------------------------------------------------------
   // Activity
   // ------------------------------------------------------------
   logic need_clk;
   logic q_acc;
   logic q_deny;
   logic p_grant;

   assign need_clk = (|upstream_port_wake_in)
                   | regport_wake_in
                   | (|down_pending) | busy;

   function automatic logic legal_state(input logic [2:0] s);
      legal_state = (s == icph_pkg::PST_OFF) | (s == icph_pkg::PST_SRET)
                  | (s == icph_pkg::PST_DRET) | (s == icph_pkg::PST_ON);
   endfunction

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         downstream_port_wake_out <= '0;
         clk_needed               <= 1'h0;
      end else begin
         downstream_port_wake_out <= down_pending;
         clk_needed               <= need_clk;
      end
   end

   // ------------------------------------------------------------
   // Clock quiescence channel
   // ------------------------------------------------------------
   icph_chan u_qch (
      .clk      (clk),
      .rst_b    (rst_b),
      .req      (~clk_quiesce_req_n),
      .grant    (~need_clk),
      .accept_q (q_acc),
      .deny_q   (q_deny)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_quiesce_accept_n <= 1'h1;
         clk_quiesce_deny     <= 1'h0;
      end else begin
         clk_quiesce_accept_n <= ~q_acc;
         clk_quiesce_deny     <= q_deny;
      end
   end

   // ------------------------------------------------------------
   // Power channel
   // ------------------------------------------------------------
   logic p_acc;
   logic p_deny;

   assign p_grant = legal_state(pwr_state)
                  & ((pwr_state == icph_pkg::PST_ON) | ~need_clk);

   icph_chan u_pch (
      .clk      (clk),
      .rst_b    (rst_b),
      .req      (pwr_req),
      .grant    (p_grant),
      .accept_q (p_acc),
      .deny_q   (p_deny)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_accept <= 1'h0;
         pwr_deny   <= 1'h0;
      end else begin
         pwr_accept <= p_acc;
         pwr_deny   <= p_deny;
      end
   end

   // Current state follows an accepted transition
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_cur_state <= icph_pkg::PST_RST;
      end else if (p_acc && !pwr_accept) begin
         pwr_cur_state <= pwr_state;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_active <= icph_pkg::ACT_RST;
      end else begin
         pwr_active                     <= '0;
         pwr_active[icph_pkg::ACT_ON]   <= 1'h1;
         pwr_active[icph_pkg::ACT_OFF]  <= ~need_clk;
         pwr_active[icph_pkg::ACT_SRET] <= ~need_clk;
         pwr_active[icph_pkg::ACT_DRET] <= ~need_clk;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_WAKE_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 downstream_port_wake_out == $past(down_pending))
      else $error("downstream wake does not follow pending");

   AST_NEED_UP: assert property (@(posedge clk) disable iff (!rst_b)
      (|upstream_port_wake_in) |=> clk_needed)
      else $error("upstream wake did not request clock");

   AST_NEED_REG: assert property (@(posedge clk) disable iff (!rst_b)
      regport_wake_in |=> clk_needed)
      else $error("register port wake did not request clock");

   AST_Q_DENY: assert property (@(posedge clk) disable iff (!rst_b)
      ($fell(clk_quiesce_req_n) && need_clk) |=> ##1 clk_quiesce_deny)
      else $error("busy clock stop not denied");

   AST_Q_ANSWER: assert property (@(posedge clk) disable iff (!rst_b)
      !clk_quiesce_req_n |-> ##[0:3]
      (!clk_quiesce_accept_n || clk_quiesce_deny))
      else $error("clock stop request not answered");

   AST_P_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
      !(pwr_accept && pwr_deny))
      else $error("power accept and deny together");

   AST_P_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
      (pwr_req && !legal_state(pwr_state) && !pwr_accept && !p_acc)
      |=> ##1 !pwr_accept)
      else $error("reserved power state accepted");

   AST_ACT_ON: assert property (@(posedge clk) disable iff (!rst_b)
      pwr_active[icph_pkg::ACT_ON] && !pwr_active[2])
      else $error("activity hint on bit or reserved bit wrong");

   AST_ACT_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
      need_clk |=> !pwr_active[icph_pkg::ACT_OFF])
      else $error("off offered while busy");

endmodule

//--- icph_pkg.sv
package icph_pkg;

   // ------------------------------------------------------------
   // Port counts
   // ------------------------------------------------------------
   localparam int unsigned NUM_UP   = 7;
   localparam int unsigned NUM_DOWN = 6;

   // ------------------------------------------------------------
   // Power state codes
   // ------------------------------------------------------------
   localparam logic [2:0] PST_OFF  = 3'h0;
   localparam logic [2:0] PST_SRET = 3'h1;
   localparam logic [2:0] PST_DRET = 3'h3;
   localparam logic [2:0] PST_ON   = 3'h4;

   // ------------------------------------------------------------
   // Activity hint bit positions
   // ------------------------------------------------------------
   localparam int unsigned ACT_OFF  = 0;
   localparam int unsigned ACT_SRET = 1;
   localparam int unsigned ACT_DRET = 3;
   localparam int unsigned ACT_ON   = 4;
   localparam logic [4:0]  ACT_RST  = 5'h10;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0] PST_RST = 3'h4;

   typedef enum logic [1:0] {
      ICPH_H_IDLE,
      ICPH_H_ACK,
      ICPH_H_NAK
   } icph_hs_type;

endpackage

//--- icph_chan.sv
`timescale 1ns/1ps

// Four-phase accept/deny responder for one request channel
module icph_chan (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic req,
   input  wire logic grant,
   output logic      accept_q,
   output logic      deny_q
);

   icph_pkg::icph_hs_type st_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= icph_pkg::ICPH_H_IDLE;
      end else begin
         unique case (st_q)
            icph_pkg::ICPH_H_IDLE: begin
               if (req) begin
                  st_q <= grant ? icph_pkg::ICPH_H_ACK
                                : icph_pkg::ICPH_H_NAK;
               end
            end
            icph_pkg::ICPH_H_ACK,
            icph_pkg::ICPH_H_NAK: begin
               if (!req) begin
                  st_q <= icph_pkg::ICPH_H_IDLE;
               end
            end
            default: st_q <= icph_pkg::ICPH_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         accept_q <= 1'h0;
         deny_q   <= 1'h0;
      end else begin
         accept_q <= (st_q == icph_pkg::ICPH_H_IDLE) ? (req & grant)
                   : (st_q == icph_pkg::ICPH_H_ACK) & req;
         deny_q   <= (st_q == icph_pkg::ICPH_H_IDLE) ? (req & ~grant)
                   : (st_q == icph_pkg::ICPH_H_NAK) & req;
      end
   end

   AST_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
      !(accept_q && deny_q))
      else $error("accept and deny together");

   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      (accept_q && req) |=> accept_q)
      else $error("accept dropped while request held");

endmodule

//--- icph_ctl_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Clock and power controller model
// ----------------------------------------
module icph_ctl_model (
   input  wire logic       clk,
   input  wire logic       q_accept_n,
   input  wire logic       q_deny,
   input  wire logic       p_accept,
   input  wire logic       p_deny,
   output logic            q_req_n,
   output logic            p_req,
   output logic      [2:0] p_state
);
   initial begin
      q_req_n = 1'h1;
      p_req   = 1'h0;
      p_state = 3'h4;
   end

   // One four-phase cycle; ch 0 is clock stop, 1 is power
   task automatic hs(input logic ch, input logic [2:0] s,
                     output logic a, output logic d);
      int n;
      n = 0;
      @(negedge clk);
      if (ch) begin
         p_state = s;
         p_req   = 1'h1;
      end else begin
         q_req_n = 1'h0;
      end
      do begin
         @(posedge clk);
         n++;
         a = ch ? p_accept : !q_accept_n;
         d = ch ? p_deny : q_deny;
      end while (!(a | d) && n < 8);
      @(negedge clk);
      p_req   = 1'h0;
      q_req_n = 1'h1;
      // Released state field no longer shows the last value
      p_state = ~s;
      n = 0;
      while ((p_accept | p_deny | !q_accept_n | q_deny) && n < 8) begin
         @(posedge clk);
         n++;
      end
   endtask
endmodule

//--- icph_top_bench.sv
`timescale 1ns/1ps

// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module icph_top_bench;
   logic       clk, rst_b, rg, bz, qrn, prq, qan, qd, pa, pd;
   logic       a, d, need, g, cn;
   logic [6:0] up;
   logic [5:0] dp, dwo;
   logic [2:0] ps, cur, pcs, s;
   logic [4:0] pact;
   int         n_fail, compares, cyc;
   integer     seed, k;

   icph_top i_dut (.clk(clk), .rst_b(rst_b),
      .upstream_port_wake_in(up), .down_pending(dp),
      .regport_wake_in(rg), .busy(bz), .clk_quiesce_req_n(qrn),
      .pwr_req(prq), .pwr_state(ps), .downstream_port_wake_out(dwo),
      .clk_needed(cn), .clk_quiesce_accept_n(qan),
      .clk_quiesce_deny(qd), .pwr_accept(pa), .pwr_deny(pd),
      .pwr_active(pact), .pwr_cur_state(pcs));

   icph_ctl_model i_ctl (.clk(clk), .q_accept_n(qan), .q_deny(qd),
      .p_accept(pa), .p_deny(pd), .q_req_n(qrn), .p_req(prq),
      .p_state(ps));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      seed = 32'h54e8;
      rst_b = 1'h0;
      {up, dp, rg, bz} = 15'h0;
      cur = 3'h4;
      repeat (16) @(negedge clk);
      chk(8'({qan, qd, pa, pd, cn}), 8'h10);
      chk(8'(pact), 8'h10);
      chk(8'(pcs), 8'h04);
      rst_b = 1'h1;
      for (int i = 0; i < 60; i++) begin
         // Inputs move on a falling edge, clear of the sampling edge
         @(negedge clk);
         k = $random(seed);
         // A quarter of the rounds leave the block wholly idle
         {up, dp, rg, bz} = (k[1:0] == 2'h0) ? 15'h0 :
                            15'($random(seed) & $random(seed));
         repeat (2) @(negedge clk);
         need = |{up, dp, rg, bz};
         chk(8'(dwo), 8'(dp));
         chk(8'(cn), 8'(need));
         chk(8'(pact), 8'({1'h1, !need, 1'h0, !need, !need}));
         i_ctl.hs(1'h0, 3'h0, a, d);
         chk(8'({a, d}), 8'({!need, need}));
         s = 3'($random(seed));
         g = (s inside {3'h0, 3'h1, 3'h3, 3'h4}) &&
             (s == 3'h4 || !need);
         i_ctl.hs(1'h1, s, a, d);
         chk(8'({a, d}), 8'({g, !g}));
         if (g)
            cur = s;
         chk(8'(pcs), 8'(cur));
      end
      end_of_test();
   end
endmodule
